// *** hdl/kpd_pkg.sv ***
/*
 * Constants for the keypad display controller: register map, field layouts,
 * reset values, display codes and timing counts.
 * Assumes a 10 MHz system clock and a 32-bit APB register bus.
 */
package kpd_pkg;
    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int DEBOUNCE_MS = 10;
    localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;
    localparam int NUM_BTN = 5;

    // ************************************************************
    // Button index
    // ************************************************************
    localparam int BTN_MODE = 0;
    localparam int BTN_UP = 1;
    localparam int BTN_DOWN = 2;
    localparam int BTN_SHIFT = 3;
    localparam int BTN_SET = 4;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATE = 8'h04;
    localparam logic [7:0] REG_INT_STATUS = 8'h08;
    localparam logic [7:0] REG_INT_MASK = 8'h0c;
    localparam logic [7:0] REG_EDIT_VALUE = 8'h10;
    localparam logic [7:0] REG_OD_ADDR = 8'h14;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [2:0] INT_MASK_RESET = 3'h0;
    localparam int INT_COMMIT = 0;
    localparam int INT_FAULT = 1;
    localparam int INT_MODE = 2;
    localparam int NUM_INT = 3;

    // ************************************************************
    // Parameter numbering and object dictionary mapping
    // ************************************************************
    localparam logic [15:0] OD_INDEX_BASE = 16'h2000;
    localparam logic [7:0] OD_SUB_BIAS = 8'h01;
    localparam logic [7:0] MONITOR_GROUP = 8'h0b;
    localparam int EDIT_DIGITS = 8;
    localparam int SEL_DIGITS = 4;
    localparam int PAGE_DIGITS = 5;

    // ************************************************************
    // Display codes
    // ************************************************************
    localparam logic [3:0] FAULT_GLYPH = 4'he;
    localparam logic [4:0] BLINK_ALL = 5'h1f;

    typedef enum logic [1:0] {
        MODE_STATUS = 2'b00,
        MODE_PARAM = 2'b01,
        MODE_FAULT = 2'b10,
        MODE_MONITOR = 2'b11
    } kpd_mode_t;

    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_NOT_READY = 2'b01,
        ST_READY = 2'b10,
        ST_RUNNING = 2'b11
    } kpd_status_t;
endpackage

// *** hdl/kpd_top.sv ***
/*
 * Keypad display controller: debounced five-button front panel, display
 * mode state machine, digit editor, status coding and APB register file.
 * Assumes the drive core status inputs are synchronous to CLK_I; button
 * and link pins are asynchronous and synchronised here. The LED driver
 * renders the digit codes and blinks the digits flagged in the mask.
 */
// Functional notes
// - Mode button goes to next display mode, or back one menu level.
// - Up raises blinking digit by one; down lowers it by one.
// - Shift moves blinking digit so digits above five are reachable.
// - Set enters next menu level and commits the edited value.
// - Object index is 0x2000 plus decimal group number.
// - Sub-index is offset within group plus one.
// - After reset the keypad shows status display.
// - Status display follows motor: rotating shows default monitor, stop returns.
// - Selecting a monitoring-group parameter switches to monitoring display.
// - A fault forces fault display at once, all digits blinking.
// - In fault display set stops blinking; then mode goes to parameters.
// - Status shows initialization until init completes, then drive status.
// - Init done without main power shows not-ready.
// - Drive able to run shows ready while awaiting servo-on.
// - Servo-on active shows running.
// - Control mode shown as one hex digit code.
// - Fieldbus state shown as code 1, 2, 4 or 8.
// - Link indicators lit steadily with link, dark without.
`timescale 1ns/1ps
module kpd_top import kpd_pkg::*; #(
    parameter int DEBOUNCE_LEN = kpd_pkg::DEBOUNCE_CYCLES
) (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic IRQ_O,
    input wire logic [kpd_pkg::NUM_BTN-1:0] BTN_I,
    input wire logic INIT_DONE_I,
    input wire logic MAIN_POWER_I,
    input wire logic DRIVE_READY_I,
    input wire logic SERVO_ON_I,
    input wire logic MOTOR_ROTATING_I,
    input wire logic FAULT_I,
    input wire logic [15:0] FAULT_CODE_I,
    input wire logic [3:0] CTRL_MODE_I,
    input wire logic [3:0] BUS_STATE_I,
    input wire logic LINK_IN_I,
    input wire logic LINK_OUT_I,
    output logic [1:0] DISP_MODE_O,
    output logic [1:0] STATUS_CODE_O,
    output logic [19:0] DIGITS_O,
    output logic [4:0] BLINK_MASK_O,
    output logic [7:0] MON_ITEM_O,
    output logic COMMIT_O,
    output logic [15:0] OD_INDEX_O,
    output logic [7:0] OD_SUB_O,
    output logic [31:0] COMMIT_VALUE_O,
    output logic LINK_IN_IND_O,
    output logic LINK_OUT_IND_O
);
    import kpd_pkg::*;

    // ************************************************************
    // Button conditioning
    // ************************************************************
    logic [NUM_BTN-1:0] press;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_BTN; gi++) begin : g_btn
            logic s1_r, s2_r, stable_r, prev_r;
            logic [31:0] cnt_r;
            always_ff @(posedge CLK_I or posedge RESET_I) begin
                if (RESET_I) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                end else begin
                    s1_r <= BTN_I[gi];
                    s2_r <= s1_r;
                end
            end
            // Level must hold unchanged for the whole window to be accepted
            always_ff @(posedge CLK_I or posedge RESET_I) begin
                if (RESET_I) begin
                    cnt_r <= 32'h0;
                    stable_r <= 1'b0;
                    prev_r <= 1'b0;
                end else begin
                    prev_r <= stable_r;
                    if (s2_r == stable_r) begin
                        cnt_r <= 32'h0;
                    end else if (cnt_r >= 32'(DEBOUNCE_LEN - 1)) begin
                        cnt_r <= 32'h0;
                        stable_r <= s2_r;
                    end else begin
                        cnt_r <= cnt_r + 32'h1;
                    end
                end
            end
            assign press[gi] = stable_r & ~prev_r;
        end
    endgenerate

    // ************************************************************
    // Link indicators
    // ************************************************************
    logic [1:0] lnk_s1_r, lnk_s2_r;
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            lnk_s1_r <= 2'b00;
            lnk_s2_r <= 2'b00;
        end else begin
            lnk_s1_r <= {LINK_OUT_I, LINK_IN_I};
            lnk_s2_r <= lnk_s1_r;
        end
    end
    assign LINK_IN_IND_O = lnk_s2_r[0];
    assign LINK_OUT_IND_O = lnk_s2_r[1];

    // ************************************************************
    // Drive status coding
    // ************************************************************
    kpd_status_t status_nxt;
    always_comb begin
        if (!INIT_DONE_I) begin
            status_nxt = ST_INIT;
        end else if (!MAIN_POWER_I) begin
            status_nxt = ST_NOT_READY;
        end else if (SERVO_ON_I) begin
            status_nxt = ST_RUNNING;
        end else if (DRIVE_READY_I) begin
            status_nxt = ST_READY;
        end else begin
            status_nxt = ST_NOT_READY;
        end
    end

    // ************************************************************
    // Display mode state machine and editor
    // ************************************************************
    kpd_mode_t mode_r;
    logic level_r, auto_mon_r, fault_blink_r, fault_prev_r, commit_r, mode_evt;
    logic [2:0] cursor_r;
    logic [15:0] sel_r;
    logic [31:0] edit_r, commit_val_r;
    logic [7:0] mon_item_r, ctrl_r, group_bin, offset_bin;
    logic [15:0] od_index_r;
    logic [7:0] od_sub_r;
    logic [2:0] cursor_max;
    logic [3:0] cur_digit;
    logic fault_rise;

    function automatic logic [3:0] bcd_step(input logic [3:0] d, input logic up);
        if (up) begin
            bcd_step = (d >= 4'h9) ? 4'h0 : d + 4'h1;
        end else begin
            bcd_step = (d == 4'h0 || d > 4'h9) ? 4'h9 : d - 4'h1;
        end
    endfunction

    assign fault_rise = FAULT_I & ~fault_prev_r;
    assign cursor_max = level_r ? 3'(EDIT_DIGITS - 1) : 3'(SEL_DIGITS - 1);
    assign cur_digit = level_r ? edit_r[cursor_r*4 +: 4] : sel_r[cursor_r[1:0]*4 +: 4];
    // Group and offset are entered as decimal digits
    assign group_bin = 8'(sel_r[15:12]) * 8'd10 + {4'h0, sel_r[11:8]};
    assign offset_bin = 8'(sel_r[7:4]) * 8'd10 + {4'h0, sel_r[3:0]};
    assign mode_evt = fault_rise || (press[BTN_MODE] && !(mode_r == MODE_FAULT
        && fault_blink_r) && !(mode_r == MODE_PARAM && level_r));

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            mode_r <= MODE_STATUS;
            level_r <= 1'b0;
            auto_mon_r <= 1'b0;
            fault_blink_r <= 1'b0;
            fault_prev_r <= 1'b0;
            mon_item_r <= 8'h00;
        end else begin
            fault_prev_r <= FAULT_I;
            if (fault_rise) begin
                mode_r <= MODE_FAULT;
                fault_blink_r <= 1'b1;
                level_r <= 1'b0;
                auto_mon_r <= 1'b0;
            end else begin
                unique case (mode_r)
                    MODE_STATUS: begin
                        if (press[BTN_MODE]) begin
                            mode_r <= MODE_PARAM;
                        end else if (MOTOR_ROTATING_I) begin
                            mode_r <= MODE_MONITOR;
                            mon_item_r <= ctrl_r;
                            auto_mon_r <= 1'b1;
                        end
                    end
                    MODE_PARAM: begin
                        if (press[BTN_MODE]) begin
                            if (level_r) begin
                                level_r <= 1'b0;
                            end else begin
                                mode_r <= MODE_MONITOR;
                                mon_item_r <= offset_bin;
                            end
                        end else if (press[BTN_SET] && !level_r) begin
                            if (group_bin == MONITOR_GROUP) begin
                                mode_r <= MODE_MONITOR;
                                mon_item_r <= offset_bin;
                            end else begin
                                level_r <= 1'b1;
                            end
                        end
                    end
                    MODE_FAULT: begin
                        if (press[BTN_SET]) begin
                            fault_blink_r <= 1'b0;
                        end else if (press[BTN_MODE] && !fault_blink_r) begin
                            mode_r <= MODE_PARAM;
                        end
                    end
                    MODE_MONITOR: begin
                        if (press[BTN_MODE]) begin
                            mode_r <= MODE_STATUS;
                            auto_mon_r <= 1'b0;
                        end else if (auto_mon_r && !MOTOR_ROTATING_I) begin
                            mode_r <= MODE_STATUS;
                            auto_mon_r <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    // Digit editor: cursor, up and down on the blinking digit
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            cursor_r <= 3'h0;
            sel_r <= 16'h0000;
            edit_r <= 32'h0;
        end else if (mode_r != MODE_PARAM || fault_rise) begin
            cursor_r <= 3'h0;
        end else if (press[BTN_SET] && !level_r) begin
            cursor_r <= 3'h0;
            edit_r <= 32'h0;
        end else if (press[BTN_MODE] && level_r) begin
            cursor_r <= 3'h0;
        end else if (press[BTN_SHIFT]) begin
            cursor_r <= (cursor_r >= cursor_max) ? 3'h0 : cursor_r + 3'h1;
        end else if (press[BTN_UP] || press[BTN_DOWN]) begin
            if (level_r) begin
                edit_r[cursor_r*4 +: 4] <= bcd_step(cur_digit, press[BTN_UP]);
            end else begin
                sel_r[cursor_r[1:0]*4 +: 4] <= bcd_step(cur_digit, press[BTN_UP]);
            end
        end
    end

    // Commit of the edited value with its object address
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            commit_r <= 1'b0;
            commit_val_r <= 32'h0;
            od_index_r <= OD_INDEX_BASE;
            od_sub_r <= OD_SUB_BIAS;
        end else begin
            commit_r <= 1'b0;
            if (mode_r == MODE_PARAM && level_r && press[BTN_SET] && !fault_rise) begin
                commit_r <= 1'b1;
                commit_val_r <= edit_r;
                od_index_r <= OD_INDEX_BASE + {8'h00, group_bin};
                od_sub_r <= offset_bin + OD_SUB_BIAS;
            end
        end
    end

    // ************************************************************
    // Display outputs
    // ************************************************************
    logic [39:0] edit_wide;
    assign edit_wide = {8'h00, edit_r};
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            DIGITS_O <= 20'h0;
            BLINK_MASK_O <= 5'h0;
            STATUS_CODE_O <= ST_INIT;
        end else begin
            STATUS_CODE_O <= status_nxt;
            unique case (mode_r)
                MODE_STATUS: begin
                    DIGITS_O <= {12'h000, CTRL_MODE_I, BUS_STATE_I};
                    BLINK_MASK_O <= 5'h0;
                end
                MODE_PARAM: begin
                    // Eight-digit values span two pages of five
                    if (level_r) begin
                        DIGITS_O <= (cursor_r >= 3'(PAGE_DIGITS)) ? edit_wide[39:20]
                                                                   : edit_wide[19:0];
                    end else begin
                        DIGITS_O <= {4'h0, sel_r};
                    end
                    BLINK_MASK_O <= 5'h1 << ((cursor_r >= 3'(PAGE_DIGITS)) ?
                        cursor_r - 3'(PAGE_DIGITS) : cursor_r);
                end
                MODE_FAULT: begin
                    DIGITS_O <= {FAULT_GLYPH, FAULT_CODE_I};
                    BLINK_MASK_O <= fault_blink_r ? BLINK_ALL : 5'h0;
                end
                MODE_MONITOR: begin
                    DIGITS_O <= {12'h000, mon_item_r};
                    BLINK_MASK_O <= 5'h0;
                end
            endcase
        end
    end
    assign DISP_MODE_O = mode_r;
    assign MON_ITEM_O = mon_item_r;
    assign COMMIT_O = commit_r;
    assign OD_INDEX_O = od_index_r;
    assign OD_SUB_O = od_sub_r;
    assign COMMIT_VALUE_O = commit_val_r;

    // ************************************************************
    // APB register file and interrupt
    // ************************************************************
    logic [NUM_INT-1:0] int_stat_r, int_mask_r, int_evt;
    logic wr_acc, setup, mapped;
    assign setup = PSEL_I & ~PENABLE_I;
    assign wr_acc = PSEL_I & PENABLE_I & PWRITE_I;
    assign mapped = PADDR_I inside {REG_CTRL, REG_STATE, REG_INT_STATUS, REG_INT_MASK,
                                    REG_EDIT_VALUE, REG_OD_ADDR};
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
    assign int_evt = {mode_evt, fault_rise, commit_r};
    assign IRQ_O = |(int_stat_r & int_mask_r);

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            ctrl_r <= CTRL_RESET;
            int_mask_r <= INT_MASK_RESET;
            int_stat_r <= '0;
        end else begin
            if (wr_acc && PADDR_I == REG_CTRL) begin
                ctrl_r <= PWDATA_I[7:0];
            end
            if (wr_acc && PADDR_I == REG_INT_MASK) begin
                int_mask_r <= PWDATA_I[NUM_INT-1:0];
            end
            // New events win over a simultaneous write-one clear
            if (wr_acc && PADDR_I == REG_INT_STATUS) begin
                int_stat_r <= (int_stat_r & ~PWDATA_I[NUM_INT-1:0]) | int_evt;
            end else begin
                int_stat_r <= int_stat_r | int_evt;
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            PRDATA_O <= 32'h0;
        end else if (setup && !PWRITE_I) begin
            unique case (PADDR_I)
                REG_CTRL: PRDATA_O <= {24'h0, ctrl_r};
                REG_STATE: PRDATA_O <= {21'h0, fault_blink_r, auto_mon_r, cursor_r,
                                       status_nxt, level_r, 1'b0, mode_r};
                REG_INT_STATUS: PRDATA_O <= {29'h0, int_stat_r};
                REG_INT_MASK: PRDATA_O <= {29'h0, int_mask_r};
                REG_EDIT_VALUE: PRDATA_O <= commit_val_r;
                REG_OD_ADDR: PRDATA_O <= {8'h0, od_index_r, od_sub_r};
                default: PRDATA_O <= 32'h0;
            endcase
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    fault_entry_a: assert property (FAULT_I && !$past(FAULT_I) |=>
        mode_r == MODE_FAULT ##1 BLINK_MASK_O == BLINK_ALL)
        else $error("fault did not force blinking fault display");
    fault_set_a: assert property (mode_r == MODE_FAULT && press[BTN_SET] && !fault_rise
        |=> !fault_blink_r)
        else $error("set did not stop fault blinking");
    fault_mode_a: assert property (mode_r == MODE_FAULT && !fault_blink_r &&
        press[BTN_MODE] && !fault_rise |=> mode_r == MODE_PARAM)
        else $error("mode did not leave fault display");
    auto_mon_a: assert property (mode_r == MODE_STATUS && MOTOR_ROTATING_I &&
        !press[BTN_MODE] && !fault_rise |=> mode_r == MODE_MONITOR && mon_item_r == $past(ctrl_r))
        else $error("rotation did not select default monitor");
    od_map_a: assert property (commit_r |-> od_index_r == OD_INDEX_BASE +
        {8'h00, $past(group_bin)} && od_sub_r == $past(offset_bin) + OD_SUB_BIAS)
        else $error("object address mapping wrong");
    status_code_a: assert property (INIT_DONE_I && MAIN_POWER_I && SERVO_ON_I
        |=> STATUS_CODE_O == ST_RUNNING)
        else $error("servo-on not shown as running");
    init_code_a: assert property (!INIT_DONE_I |=> STATUS_CODE_O == ST_INIT)
        else $error("initialization not shown");
    power_code_a: assert property (INIT_DONE_I && !MAIN_POWER_I
        |=> STATUS_CODE_O == ST_NOT_READY)
        else $error("missing main power not shown as not ready");
    ready_code_a: assert property (INIT_DONE_I && MAIN_POWER_I && !SERVO_ON_I &&
        DRIVE_READY_I |=> STATUS_CODE_O == ST_READY)
        else $error("ready state not shown");
    link_ind_a: assert property ($rose(LINK_IN_I) ##1 LINK_IN_I |=> LINK_IN_IND_O)
        else $error("link indicator not lit");
    press_once_a: assert property (press[BTN_SET] |-> $past(g_btn[BTN_SET].s2_r, 2)
        ##1 !press[BTN_SET])
        else $error("button acted twice on one press");
    up_step_a: assert property (mode_r == MODE_PARAM && level_r && press[BTN_UP] &&
        !press[BTN_SET] && !press[BTN_MODE] && !press[BTN_SHIFT] && !fault_rise &&
        cur_digit < 4'h9 |=> cur_digit == $past(cur_digit) + 4'h1)
        else $error("up did not raise the blinking digit");
endmodule // kpd_top

// *** bench/kpd_operator.sv ***
/* Operator model: presses one keypad button at a time, held then released.
   Assumes it shares the bench clock and reset. */
`timescale 1ns/1ps
module kpd_operator #(
    parameter int HOLD = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic [2:0] key_i,
    input wire logic short_i,
    output logic [4:0] btn_o,
    output logic busy_o
);
    int cnt_r;
    assign busy_o = (cnt_r != 0);
    // Clean press, held well past the debounce span
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= 0;
            btn_o <= 5'h00;
        end else if (go_i && !busy_o) begin
            // Short press stays under the debounce span and must be ignored
            cnt_r <= short_i ? HOLD + 2 : 2 * HOLD;
            btn_o <= 5'h01 << key_i;
        end else if (busy_o) begin
            cnt_r <= cnt_r - 1;
            if (cnt_r == HOLD) begin
                btn_o <= 5'h00;
            end
        end
    end
endmodule // kpd_operator

// *** bench/kpd_top_tb_top.sv ***
/* Bench for the keypad controller: status rows, keys, APB, fault.
   Assumes a debounce span of 4 cycles and the operator model. */
`timescale 1ns/1ps
module kpd_top_tb_top;
    import kpd_pkg::*;
    logic clk = 0, rst, psel = 0, pen = 0, pw = 0, go = 0, busy, slverr, shrt = 0;
    logic [7:0] pa = 0;
    logic [31:0] pwd = 0, q;
    logic [2:0] key = 0;
    logic [4:0] btn;
    logic [3:0] st = 0, cm = 0, bs = 0;
    logic rot = 0, flt = 0, lin = 0, lout = 0;
    logic [15:0] fc = 0;
    wire [31:0] prd, cval;
    wire prdy, perr, irq, commit, lin_o, lout_o;
    wire [1:0] mode, scode;
    wire [19:0] dig;
    wire [4:0] blink;
    wire [15:0] odi;
    wire [7:0] ods, mon;
    int num_errors = 0, samples_checked = 0, commits = 0;
    logic [15:0] rows [7] = '{16'h1100, 16'h3281, 16'h44c1, 16'h68e2, 16'h81f3,
        16'h92d3, 16'ha470};
    always #50 clk = ~clk;
    always @(posedge clk) begin
        if (commit === 1'b1) commits++;
    end
    kpd_operator #(.HOLD(12)) op (.clk_i(clk), .rst_i(rst), .go_i(go), .key_i(key),
        .short_i(shrt), .btn_o(btn), .busy_o(busy));
    kpd_top #(.DEBOUNCE_LEN(4)) DUT (.CLK_I(clk), .RESET_I(rst), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pw), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd),
        .PREADY_O(prdy), .PSLVERR_O(perr), .IRQ_O(irq), .BTN_I(btn), .INIT_DONE_I(st[3]),
        .MAIN_POWER_I(st[2]), .DRIVE_READY_I(st[1]), .SERVO_ON_I(st[0]),
        .MOTOR_ROTATING_I(rot), .FAULT_I(flt), .FAULT_CODE_I(fc), .CTRL_MODE_I(cm),
        .BUS_STATE_I(bs), .LINK_IN_I(lin), .LINK_OUT_I(lout), .DISP_MODE_O(mode),
        .STATUS_CODE_O(scode), .DIGITS_O(dig), .BLINK_MASK_O(blink), .MON_ITEM_O(mon),
        .COMMIT_O(commit), .OD_INDEX_O(odi), .OD_SUB_O(ods), .COMMIT_VALUE_O(cval),
        .LINK_IN_IND_O(lin_o), .LINK_OUT_IND_O(lout_o));
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; pw <= w; pa <= a; pwd <= d;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (prdy !== 1'b1) @(posedge clk);
        q = prd;
        slverr = perr;
        psel <= 0; pen <= 0;
        @(posedge clk);
    endtask
    task press(input int k);
        key <= 3'(k); go <= 1;
        @(posedge clk);
        go <= 0;
        @(posedge clk);
        while (busy === 1'b1) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask
    task results;
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        results();
    end
    initial begin
        rst = 1;
        repeat (8) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        chk(mode, MODE_STATUS);
        chk({odi, ods}, 24'h200001);
        foreach (rows[i]) begin
            st <= rows[i][7:4]; cm <= rows[i][15:12]; bs <= rows[i][11:8];
            lin <= rows[i][6]; lout <= rows[i][4];
            repeat (4) @(posedge clk);
            chk(scode, rows[i][1:0]);
            chk(dig, {12'h000, rows[i][15:8]});
            chk({lin_o, lout_o}, {rows[i][6], rows[i][4]});
        end
        $display("status rows done");
        apb(1, REG_CTRL, 32'h07);
        rot <= 1;
        repeat (4) @(posedge clk);
        chk({mode, mon}, {MODE_MONITOR, 8'h07});
        rot <= 0;
        repeat (4) @(posedge clk);
        chk(mode, MODE_STATUS);
        apb(0, REG_INT_MASK, 0);
        chk(q, 0);
        apb(1, REG_INT_MASK, 1);
        apb(0, 8'h3c, 0);
        chk(slverr, 1);
        chk(q, 0);
        press(BTN_MODE);
        chk(mode, MODE_PARAM);
        shrt <= 1;
        press(BTN_MODE);
        shrt <= 0;
        chk(mode, MODE_PARAM);
        for (int i = 0; i < 7; i++) press(i < 6 ? BTN_UP : BTN_DOWN);
        press(BTN_SHIFT);
        press(BTN_SHIFT);
        press(BTN_UP);
        chk(dig, 20'h00105);
        press(BTN_SET);
        press(BTN_UP);
        repeat (5) press(BTN_SHIFT);
        press(BTN_UP);
        chk({dig, blink}, {20'h00001, 5'h01});
        press(BTN_SET);
        chk({odi, ods}, 24'h200106);
        chk(cval, 32'h00100001);
        chk(commits, 1);
        chk(irq, 1);
        apb(0, REG_INT_STATUS, 0);
        chk(q[0], 1);
        apb(1, REG_INT_STATUS, 1);
        chk(irq, 0);
        press(BTN_MODE);
        apb(0, REG_STATE, 0);
        chk(q, 32'h00000001);
        $display("edit and commit done");
        fc <= 16'h9410; flt <= 1;
        repeat (4) @(posedge clk);
        chk({mode, blink, dig}, {MODE_FAULT, BLINK_ALL, 20'he9410});
        press(BTN_MODE);
        chk(mode, MODE_FAULT);
        press(BTN_SET);
        chk(blink, 0);
        flt <= 0;
        press(BTN_MODE);
        chk(mode, MODE_PARAM);
        repeat (3) press(BTN_SHIFT);
        press(BTN_UP);
        press(BTN_SET);
        chk({mode, mon}, {MODE_MONITOR, 8'h05});
        $display("fault done");
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        chk(mode, MODE_STATUS);
        $display("second reset done");
        results();
    end
endmodule // kpd_top_tb_top
